// >>> hw/eng_nmt_guard.sv
// What this block does
// - Warning bits stay set while their tolerance is exceeded; position stays valid.
// - Warning bit 0 overspeed above 10000 r/min, bit 2 watchdog, bit 3 operating time.
// - Overspeed warning rising sends emergency on 80h plus node, code FF00h.
// - Watchdog or operating-time warning rising sends emergency code 5000h.
// - Supported-warnings word reads bits 0, 2 and 3 set, rest zero.
// - Version word: profile version low half, firmware version high half.
// - Operating-time counter increments every six minutes, one count per 0.1 hours.
// - Operating time past 100000 hours sets warning bit 3.
// - Preset write becomes a signed 32-bit offset readable as object.
// - Offset equals preset minus position (a preset of FFFFFFFFh clears it to 0), added to every later position.
// - After reset the node initialises, then enters pre-operational on its own.
// - Pre-operational accepts service data and parameterisation.
// - Process data only delivered while operational.
// - Stopped refuses service and process data; leaves to operational, pre-operational or, on 81h or 82h, initialisation.
// - Management frames use identifier 0, two bytes: command then node number.
// - Node acts on management frames addressed to its number or to 0.
// - Command 01h operational, 02h stopped, 80h pre-operational.
// - Command 81h resets the node and every parameter to power-on values.
// - Command 82h resets communication parameters only.
// - Guarding requests are answered with a status message.
// - Guarding identifier is configurable, defaulting to 700h plus node number.
// - Life time equals guard time multiplied by life-time factor.
module eng_nmt_guard #(
  parameter int MS_CYC = eng_pkg::MS_CYCLES,
  parameter int OPT_MS = eng_pkg::OPTIME_MS,
  parameter logic [31:0] SERIAL_NO = eng_pkg::SERIAL_DEFAULT
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic en_i,
  input wire logic [6:0] node_id_i,
  input wire logic rx_valid_i,
  input wire logic [10:0] rx_id_i,
  input wire logic rx_rtr_i,
  input wire logic [3:0] rx_dlc_i,
  input wire logic [15:0] rx_data_i,
  input wire logic tx_ready_i,
  input wire logic [15:0] speed_rpm_i,
  input wire logic wdt_reset_i,
  input wire logic [31:0] raw_pos_i,
  input wire logic preset_wr_i,
  input wire logic [31:0] preset_i,
  input wire logic [31:0] factory_offset_i,
  input wire logic cfg_wr_i,
  input wire logic [1:0] cfg_sel_i,
  input wire logic [15:0] cfg_data_i,
  input wire logic od_rd_i,
  input wire logic [15:0] od_index_i,
  output logic tx_valid_o,
  output logic [10:0] tx_id_o,
  output logic [3:0] tx_dlc_o,
  output logic [63:0] tx_data_o,
  output logic od_rvalid_o,
  output logic od_err_o,
  output logic [31:0] od_rdata_o,
  output logic [31:0] pos_o,
  output logic sdo_en_o,
  output logic pdo_en_o,
  output logic life_lost_o,
  output logic [6:0] node_state_o
);
  import eng_pkg::*;
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ND_INIT, ND_PREOP, ND_OP, ND_STOP} eng_node_e;
  typedef struct packed {
    eng_node_e state;
    logic [6:0] node_id;
    logic toggle;
    logic [10:0] guard_id;
    logic [15:0] guard_time;
    logic [7:0] life_factor;
    logic [23:0] life_ms;
    logic life_lost;
    logic [13:0] ms_cnt;
    logic [18:0] opt_ms;
    logic [31:0] op_time;
    logic [15:0] warn;
    logic [1:0] emcy_pend;
    logic guard_pend;
    logic [31:0] offset;
    logic [31:0] pos;
    logic tx_valid;
    logic [10:0] tx_id;
    logic [3:0] tx_dlc;
    logic [63:0] tx_data;
    logic od_rvalid;
    logic od_err;
    logic [31:0] od_rdata;
    logic sdo_en;
    logic pdo_en;
    logic [6:0] code;
  } eng_state_s;
  eng_state_s r, next_r;
  logic rst_meta, rst_sync_n;
  // Emergency payload: code low byte first, error register, zero fill
  function automatic logic [63:0] emcy_frame(input logic [15:0] code);
    emcy_frame = {40'h0000000000, 8'h01, code[15:8], code[7:0]};
  endfunction
  // Reply code for the current node state
  function automatic logic [6:0] state_code(input eng_node_e s);
    case (s)
      ND_OP: state_code = CODE_OPERATIONAL;
      ND_STOP: state_code = CODE_STOPPED;
      default: state_code = CODE_PREOP;
    endcase
  endfunction
  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  // Release is synchronised so all flops leave reset on the same edge
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end
  // Decoded receive events
  logic nmt_hit, guard_req, ms_tick, tx_free;
  logic [7:0] cmd;
  logic [23:0] life_time;
  assign cmd = rx_data_i[7:0];
  assign nmt_hit = rx_valid_i && !rx_rtr_i && rx_id_i == NMT_ID && rx_dlc_i == NMT_DLC &&
                   (rx_data_i[15:8] == {1'b0, r.node_id} || rx_data_i[15:8] == NMT_BROADCAST);
  assign guard_req = rx_valid_i && rx_rtr_i && rx_id_i == r.guard_id && r.state != ND_INIT;
  assign life_time = {8'h00, r.guard_time} * {16'h0000, r.life_factor};
  assign ms_tick = r.ms_cnt == 14'(MS_CYC - 1);
  assign tx_free = !r.tx_valid || tx_ready_i;
  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.od_rvalid = 1'b0;
    next_r.od_err = 1'b0;
    // Millisecond base and operating time; runs in every state
    next_r.ms_cnt = ms_tick ? 14'h0000 : r.ms_cnt + 14'h0001;
    if (ms_tick) begin
      if (r.opt_ms == 19'(OPT_MS - 1)) begin
        next_r.opt_ms = 19'h00000;
        next_r.op_time = r.op_time + 32'h00000001;
      end else begin
        next_r.opt_ms = r.opt_ms + 19'h00001;
      end
    end
    // Level warnings follow their cause, emergencies fire on the rise
    next_r.warn = 16'h0000;
    next_r.warn[WARN_SPEED_BIT] = speed_rpm_i > SPEED_LIMIT_RPM;
    next_r.warn[WARN_WDT_BIT] = wdt_reset_i;
    next_r.warn[WARN_OPTIME_BIT] = r.op_time > OPTIME_LIMIT;
    if (next_r.warn[WARN_SPEED_BIT] && !r.warn[WARN_SPEED_BIT]) begin
      next_r.emcy_pend[0] = 1'b1;
    end
    if ((next_r.warn[WARN_WDT_BIT] && !r.warn[WARN_WDT_BIT]) ||
        (next_r.warn[WARN_OPTIME_BIT] && !r.warn[WARN_OPTIME_BIT])) begin
      next_r.emcy_pend[1] = 1'b1;
    end
    // Life guarding: the master's request restarts the window
    if (guard_req) begin
      next_r.guard_pend = 1'b1;
      next_r.life_ms = 24'h000000;
      next_r.life_lost = 1'b0;
    end else if (ms_tick && life_time != 24'h000000) begin
      if (r.life_ms >= life_time) begin
        next_r.life_lost = 1'b1;
      end else begin
        next_r.life_ms = r.life_ms + 24'h000001;
      end
    end
    // Transmit slot: guard reply beats emergencies, pending wins over clear
    if (r.tx_valid && tx_ready_i) begin
      next_r.tx_valid = 1'b0;
      if (r.tx_dlc == GUARD_DLC) begin
        next_r.toggle = !r.toggle;
      end
    end
    if (tx_free && r.state != ND_INIT) begin
      if (r.guard_pend) begin
        next_r.tx_valid = 1'b1;
        next_r.tx_id = r.guard_id;
        next_r.tx_dlc = GUARD_DLC;
        next_r.tx_data = {56'h0, next_r.toggle, state_code(r.state)};
        next_r.guard_pend = guard_req;
      end else if (r.emcy_pend[0]) begin
        next_r.tx_valid = 1'b1;
        next_r.tx_id = EMCY_BASE + {4'h0, r.node_id};
        next_r.tx_dlc = EMCY_DLC;
        next_r.tx_data = emcy_frame(EMCY_SPEED_CODE);
        next_r.emcy_pend[0] = next_r.warn[WARN_SPEED_BIT] && !r.warn[WARN_SPEED_BIT];
      end else if (r.emcy_pend[1]) begin
        next_r.tx_valid = 1'b1;
        next_r.tx_id = EMCY_BASE + {4'h0, r.node_id};
        next_r.tx_dlc = EMCY_DLC;
        next_r.tx_data = emcy_frame(EMCY_HW_CODE);
        // A fresh rise in the same cycle must not be lost with the clear
        next_r.emcy_pend[1] = (next_r.warn[WARN_WDT_BIT] && !r.warn[WARN_WDT_BIT]) ||
                              (next_r.warn[WARN_OPTIME_BIT] && !r.warn[WARN_OPTIME_BIT]);
      end
    end
    // Preset turns into an offset, added to each reported position
    if (preset_wr_i) begin
      next_r.offset = (preset_i == PRESET_CLEAR) ? 32'h00000000 : preset_i - raw_pos_i;
    end
    next_r.pos = raw_pos_i + r.offset;
    // Parameterisation only while pre-operational
    if (cfg_wr_i && r.state == ND_PREOP) begin
      if (cfg_sel_i == CFG_GUARD_ID) begin
        next_r.guard_id = cfg_data_i[10:0];
      end else if (cfg_sel_i == CFG_GUARD_TIME) begin
        next_r.guard_time = cfg_data_i;
      end else if (cfg_sel_i == CFG_LIFE_FACTOR) begin
        next_r.life_factor = cfg_data_i[7:0];
      end
    end
    // Object reads; refused while stopped or for unknown indices
    if (od_rd_i) begin
      next_r.od_rvalid = 1'b1;
      next_r.od_rdata = 32'h00000000;
      if (r.state == ND_STOP || r.state == ND_INIT) begin
        next_r.od_err = 1'b1;
      end else if (od_index_i == IDX_WARN_STATUS) begin
        next_r.od_rdata = {16'h0000, r.warn};
      end else if (od_index_i == IDX_WARN_SUPPORTED) begin
        next_r.od_rdata = {16'h0000, WARN_SUPPORTED_VAL};
      end else if (od_index_i == IDX_VERSION) begin
        next_r.od_rdata = {FIRMWARE_VERSION, PROFILE_VERSION};
      end else if (od_index_i == IDX_OPTIME) begin
        next_r.od_rdata = r.op_time;
      end else if (od_index_i == IDX_PRESET_OFFSET) begin
        next_r.od_rdata = r.offset;
      end else if (od_index_i == IDX_FACTORY_OFFSET) begin
        next_r.od_rdata = factory_offset_i;
      end else if (od_index_i == IDX_SERIAL) begin
        next_r.od_rdata = SERIAL_NO;
      end else begin
        next_r.od_err = 1'b1;
      end
    end
    // Node state machine
    case (r.state)
      ND_INIT: begin
        // Communication defaults follow the node number caught here
        next_r.node_id = node_id_i;
        next_r.guard_id = GUARD_BASE + {4'h0, node_id_i};
        next_r.toggle = 1'b0;
        next_r.guard_time = 16'h0000;
        next_r.life_factor = 8'h00;
        next_r.life_ms = 24'h000000;
        next_r.life_lost = 1'b0;
        next_r.guard_pend = 1'b0;
        next_r.state = ND_PREOP;
      end
      default: begin
        if (nmt_hit) begin
          if (cmd == CMD_START) begin
            next_r.state = ND_OP;
          end else if (cmd == CMD_STOP) begin
            next_r.state = ND_STOP;
          end else if (cmd == CMD_PREOP) begin
            next_r.state = ND_PREOP;
          end else if (cmd == CMD_RESET_NODE) begin
            next_r.offset = 32'h00000000;
            next_r.state = ND_INIT;
          end else if (cmd == CMD_RESET_COMM) begin
            next_r.state = ND_INIT;
          end
        end
      end
    endcase
    next_r.sdo_en = next_r.state == ND_PREOP || next_r.state == ND_OP;
    next_r.pdo_en = next_r.state == ND_OP;
    next_r.code = next_r.state == ND_INIT ? 7'h00 : state_code(next_r.state);
  end
  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // Clock enable freezes everything, including the time base
  always_ff @(posedge clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      r <= '0;
    end else if (en_i) begin
      r <= next_r;
    end
  end
  // Outputs come straight from the state register
  assign tx_valid_o = r.tx_valid;
  assign tx_id_o = r.tx_id;
  assign tx_dlc_o = r.tx_dlc;
  assign tx_data_o = r.tx_data;
  assign od_rvalid_o = r.od_rvalid;
  assign od_err_o = r.od_err;
  assign od_rdata_o = r.od_rdata;
  assign pos_o = r.pos;
  assign sdo_en_o = r.sdo_en;
  assign pdo_en_o = r.pdo_en;
  assign life_lost_o = r.life_lost;
  assign node_state_o = r.code;
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_sync_n);
  property p_init_leaves;
    r.state == ND_INIT && en_i |=> r.state == ND_PREOP;
  endproperty
  a_init_leaves: assert property (p_init_leaves) else $error("init did not reach preop");
  property p_stop_cmd;
    en_i && r.state != ND_INIT && nmt_hit && cmd == CMD_STOP |=> r.state == ND_STOP && !r.sdo_en;
  endproperty
  a_stop_cmd: assert property (p_stop_cmd) else $error("stop command ignored");
  property p_foreign_node;
    en_i && rx_valid_i && !rx_rtr_i && rx_id_i == NMT_ID && rx_data_i[15:8] != {1'b0, r.node_id} &&
    rx_data_i[15:8] != NMT_BROADCAST && r.state != ND_INIT |=> r.state == $past(r.state);
  endproperty
  a_foreign_node: assert property (p_foreign_node) else $error("acted on foreign node");
  property p_guard_default;
    r.state == ND_INIT && en_i |=> r.guard_id == GUARD_BASE + {4'h0, r.node_id} && !r.toggle;
  endproperty
  a_guard_default: assert property (p_guard_default) else $error("guard id default wrong");
  property p_speed_warn;
    en_i && speed_rpm_i > SPEED_LIMIT_RPM ##1 en_i && speed_rpm_i > SPEED_LIMIT_RPM |=> r.warn[WARN_SPEED_BIT];
  endproperty
  a_speed_warn: assert property (p_speed_warn) else $error("overspeed warning missing");
  property p_speed_emcy;
    $rose(r.warn[WARN_SPEED_BIT]) |-> r.emcy_pend[0] || (r.tx_valid && r.tx_data[15:0] == EMCY_SPEED_CODE);
  endproperty
  a_speed_emcy: assert property (p_speed_emcy) else $error("no overspeed emergency");
  property p_supported;
    en_i && od_rd_i && od_index_i == IDX_WARN_SUPPORTED && r.state inside {ND_PREOP, ND_OP}
    |=> od_rvalid_o && !od_err_o && od_rdata_o == 32'h0000000d;
  endproperty
  a_supported: assert property (p_supported) else $error("supported warnings wrong");
  property p_stop_refuse;
    en_i && od_rd_i && r.state == ND_STOP |=> od_err_o && od_rvalid_o;
  endproperty
  a_stop_refuse: assert property (p_stop_refuse) else $error("read served while stopped");
  property p_pdo_only_op;
    pdo_en_o |-> r.state == ND_OP && sdo_en_o;
  endproperty
  a_pdo_only_op: assert property (p_pdo_only_op) else $error("process data outside operational");
  property p_toggle_flip;
    en_i && r.tx_valid && tx_ready_i && r.tx_dlc == GUARD_DLC && r.state != ND_INIT |=> r.toggle != $past(r.toggle);
  endproperty
  a_toggle_flip: assert property (p_toggle_flip) else $error("toggle did not alternate");
  property p_tx_hold;
    r.tx_valid && !tx_ready_i |=> r.tx_valid && $stable(r.tx_data) && $stable(r.tx_id);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("frame dropped before accept");
  c_guard_reply: cover property (guard_req ##[1:4] r.tx_valid && r.tx_dlc == GUARD_DLC);
  c_start: cover property (r.state == ND_PREOP ##1 r.state == ND_OP);
  c_reset_comm: cover property (nmt_hit && cmd == CMD_RESET_COMM ##1 r.state == ND_INIT);
  c_speed_emcy: cover property (r.tx_valid && r.tx_data[15:0] == EMCY_SPEED_CODE);
endmodule

// >>> hw/eng_pkg.sv
package eng_pkg;
  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 10000000;
  localparam int TICK_MS = 1;
  localparam int MS_CYCLES = (CLK_HZ / 1000) * TICK_MS;
  localparam int OPTIME_MINUTES = 6;
  localparam int OPTIME_MS = OPTIME_MINUTES * 60 * 1000;

  // ---------------------------------------------------------------
  // Object indices
  // ---------------------------------------------------------------
  localparam logic [15:0] IDX_WARN_STATUS = 16'h6505;
  localparam logic [15:0] IDX_WARN_SUPPORTED = 16'h6506;
  localparam logic [15:0] IDX_VERSION = 16'h6507;
  localparam logic [15:0] IDX_OPTIME = 16'h6508;
  localparam logic [15:0] IDX_PRESET_OFFSET = 16'h6509;
  localparam logic [15:0] IDX_FACTORY_OFFSET = 16'h650a;
  localparam logic [15:0] IDX_SERIAL = 16'h650b;

  // ---------------------------------------------------------------
  // Warning word layout and limits
  // ---------------------------------------------------------------
  localparam int WARN_SPEED_BIT = 0;
  localparam int WARN_WDT_BIT = 2;
  localparam int WARN_OPTIME_BIT = 3;
  localparam logic [15:0] WARN_SUPPORTED_VAL = 16'h000d;
  localparam logic [15:0] SPEED_LIMIT_RPM = 16'h2710;
  localparam logic [31:0] OPTIME_LIMIT = 32'h000f4240;

  // ---------------------------------------------------------------
  // Frame identifiers, commands, codes
  // ---------------------------------------------------------------
  localparam logic [10:0] NMT_ID = 11'h000;
  localparam logic [10:0] EMCY_BASE = 11'h080;
  localparam logic [10:0] GUARD_BASE = 11'h700;
  localparam logic [7:0] NMT_BROADCAST = 8'h00;
  localparam logic [3:0] NMT_DLC = 4'h2;
  localparam logic [7:0] CMD_START = 8'h01;
  localparam logic [7:0] CMD_STOP = 8'h02;
  localparam logic [7:0] CMD_PREOP = 8'h80;
  localparam logic [7:0] CMD_RESET_NODE = 8'h81;
  localparam logic [7:0] CMD_RESET_COMM = 8'h82;
  localparam logic [15:0] EMCY_SPEED_CODE = 16'hff00;
  localparam logic [15:0] EMCY_HW_CODE = 16'h5000;
  localparam logic [3:0] EMCY_DLC = 4'h8;
  localparam logic [3:0] GUARD_DLC = 4'h1;
  localparam logic [31:0] PRESET_CLEAR = 32'hffffffff;

  // Guarding reply state codes
  localparam logic [6:0] CODE_STOPPED = 7'h04;
  localparam logic [6:0] CODE_OPERATIONAL = 7'h05;
  localparam logic [6:0] CODE_PREOP = 7'h7f;

  // Configuration selectors
  localparam logic [1:0] CFG_GUARD_ID = 2'h0;
  localparam logic [1:0] CFG_GUARD_TIME = 2'h1;
  localparam logic [1:0] CFG_LIFE_FACTOR = 2'h2;

  // Version and identity values (arbitrary neutral values)
  localparam logic [15:0] PROFILE_VERSION = 16'h0001;
  localparam logic [15:0] FIRMWARE_VERSION = 16'h0001;
  localparam logic [31:0] SERIAL_DEFAULT = 32'h00000001;
endpackage

// >>> test/eng_can_master.sv
// ---------------------------------------------------------------
// Network master on the far side of the bus
// ---------------------------------------------------------------
module eng_can_master (
  input wire logic clk_i,
  input wire logic tx_valid_i,
  input wire logic [10:0] tx_id_i,
  input wire logic [3:0] tx_dlc_i,
  input wire logic [63:0] tx_data_i,
  input wire logic [3:0] lag_i,
  output logic rx_valid_o,
  output logic [10:0] rx_id_o,
  output logic rx_rtr_o,
  output logic [3:0] rx_dlc_o,
  output logic [15:0] rx_data_o,
  output logic tx_ready_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [10:0] got_id;
  logic [3:0] got_dlc;
  logic [63:0] got_data;
  logic last_tgl = 1'b0;
  logic seen = 1'b0;
  int got_n = 0;
  int wait_n = 0;
  int tgl_bad = 0;

  // Idle bus fields carry junk, so nothing may lean on stale values
  initial begin
    rx_valid_o = 1'b0;
    rx_id_o = 11'h000;
    rx_rtr_o = 1'b0;
    rx_dlc_o = 4'h0;
    rx_data_o = 16'h0000;
  end

  // One frame for one cycle; management frames go on identifier 0
  task automatic send(input logic [10:0] id, input logic rtr, input logic [3:0] dlc, input logic [15:0] d);
    @(posedge clk_i);
    #1;
    rx_valid_o = 1'b1;
    rx_id_o = id;
    rx_rtr_o = rtr;
    rx_dlc_o = dlc;
    rx_data_o = d;
    @(posedge clk_i);
    #1;
    rx_valid_o = 1'b0;
    rx_id_o = ~id;
    rx_dlc_o = ~dlc;
    rx_data_o = ~d;
  endtask

  // After a node or communication reset the toggle history is void
  task automatic forget();
    seen = 1'b0;
  endtask

  // Slow acceptance: ready only after lag_i cycles of offer
  assign tx_ready_o = tx_valid_i && (wait_n >= lag_i);
  always @(posedge clk_i) begin
    wait_n <= (tx_valid_i && !tx_ready_o) ? wait_n + 1 : 0;
  end

  // Take each frame; a guard reply repeating its toggle is a failure
  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o) begin
      got_id <= tx_id_i;
      got_dlc <= tx_dlc_i;
      got_data <= tx_data_i;
      got_n <= got_n + 1;
      if (tx_dlc_i == 4'h1) begin
        if (seen && tx_data_i[7] == last_tgl) tgl_bad <= tgl_bad + 1;
        last_tgl <= tx_data_i[7];
        seen <= 1'b1;
      end
    end
  end
endmodule

// >>> test/eng_nmt_guard_tb_top.sv
module eng_nmt_guard_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, arst_n_i, rx_valid_i, rx_rtr_i, tx_ready_i, wdt_reset_i, preset_wr_i, cfg_wr_i, od_rd_i, en;
  logic tx_valid_o, od_rvalid_o, od_err_o, sdo_en_o, pdo_en_o, life_lost_o;
  logic [10:0] rx_id_i, tx_id_o;
  logic [3:0] rx_dlc_i, tx_dlc_o, lag;
  logic [15:0] rx_data_i, speed_rpm_i, cfg_data_i, od_index_i;
  logic [31:0] raw_pos_i, preset_i, od_rdata_o, pos_o, t0;
  logic [63:0] tx_data_o;
  logic [6:0] node_state_o;
  logic [1:0] cfg_sel_i;
  int fails = 0;
  int total_checks = 0;
  int seen_n = 0;
  int cyc = 0;
  int k;

  // Short time base: 4 cycles a ms, 3 ms a count, so 12 cycles a count
  eng_nmt_guard #(.MS_CYC(4), .OPT_MS(3), .SERIAL_NO(32'h00000a5a)) u_dut (
    .clk_i, .arst_n_i, .en_i(en), .node_id_i(7'h05), .rx_valid_i, .rx_id_i, .rx_rtr_i, .rx_dlc_i,
    .rx_data_i, .tx_ready_i, .speed_rpm_i, .wdt_reset_i, .raw_pos_i, .preset_wr_i, .preset_i,
    .factory_offset_i(32'h00001234), .cfg_wr_i, .cfg_sel_i, .cfg_data_i, .od_rd_i, .od_index_i,
    .tx_valid_o, .tx_id_o, .tx_dlc_o, .tx_data_o, .od_rvalid_o, .od_err_o, .od_rdata_o, .pos_o,
    .sdo_en_o, .pdo_en_o, .life_lost_o, .node_state_o);
  eng_can_master u_m (
    .clk_i, .tx_valid_i(tx_valid_o), .tx_id_i(tx_id_o), .tx_dlc_i(tx_dlc_o), .tx_data_i(tx_data_o),
    .lag_i(lag), .rx_valid_o(rx_valid_i), .rx_id_o(rx_id_i), .rx_rtr_o(rx_rtr_i), .rx_dlc_o(rx_dlc_i),
    .rx_data_o(rx_data_i), .tx_ready_o(tx_ready_i));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, s, e);
    end
  endtask
  task automatic rd(input logic [15:0] idx, input logic [31:0] exp, input logic err);
    @(posedge clk_i);
    #1;
    od_rd_i = 1'b1;
    od_index_i = idx;
    @(posedge clk_i);
    #1;
    od_rd_i = 1'b0;
    chk(od_rvalid_o, 1'b1);
    chk(od_err_o, err);
    chk(od_rdata_o, exp);
  endtask
  // Waits a bounded time for the next frame the master accepted
  task automatic wf(input logic [10:0] id, input logic [3:0] dlc, input logic [63:0] d, input logic [63:0] m);
    k = 0;
    while (u_m.got_n <= seen_n && k < 60) begin
      @(posedge clk_i);
      #1;
      k++;
    end
    seen_n = u_m.got_n;
    chk(k < 60, 1'b1);
    chk(u_m.got_id, id);
    chk(u_m.got_dlc, dlc);
    chk(u_m.got_data & m, d);
  endtask
  task automatic nmt(input logic [7:0] cmd, input logic [7:0] node);
    u_m.send(11'h000, 1'b0, 4'h2, {node, cmd});
    @(posedge clk_i);
    #1;
  endtask
  task automatic cfg(input logic [1:0] sel, input logic [15:0] d);
    @(posedge clk_i);
    #1;
    cfg_wr_i = 1'b1;
    cfg_sel_i = sel;
    cfg_data_i = d;
    @(posedge clk_i);
    #1;
    cfg_wr_i = 1'b0;
  endtask

  // ---------------------------------------------------------------
  // Clock and hang guard
  // ---------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 5000) begin
      fails++;
      give_verdict();
    end
  end

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    {arst_n_i, wdt_reset_i, preset_wr_i, cfg_wr_i, od_rd_i, cfg_sel_i} = '0;
    {speed_rpm_i, cfg_data_i, od_index_i, raw_pos_i, preset_i} = '0;
    lag = 4'h3;
    en = 1'b1;
    repeat (20) @(posedge clk_i);
    #1;
    arst_n_i = 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    chk({node_state_o, sdo_en_o, pdo_en_o}, {7'h7f, 2'b10});
    rd(16'h6505, 32'h0, 1'b0);
    rd(16'h6506, 32'h0000000d, 1'b0);
    rd(16'h6507, 32'h00010001, 1'b0);
    rd(16'h650a, 32'h00001234, 1'b0);
    rd(16'h650b, 32'h00000a5a, 1'b0);
    rd(16'h6504, 32'h0, 1'b1);
    // Guard replies toggle bit 7, starting from 0
    u_m.send(11'h705, 1'b1, 4'h0, 16'h0);
    wf(11'h705, 4'h1, 64'h7f, 64'hff);
    u_m.send(11'h705, 1'b1, 4'h0, 16'h0);
    wf(11'h705, 4'h1, 64'hff, 64'hff);
    nmt(8'h01, 8'h06);
    chk(node_state_o, 7'h7f);
    nmt(8'h01, 8'h05);
    chk({node_state_o, pdo_en_o}, {7'h05, 1'b1});
    u_m.send(11'h000, 1'b0, 4'h3, 16'h0502);
    chk(node_state_o, 7'h05);
    nmt(8'h02, 8'h00);
    chk({node_state_o, sdo_en_o, pdo_en_o}, {7'h04, 2'b00});
    rd(16'h6506, 32'h0, 1'b1);
    u_m.send(11'h705, 1'b1, 4'h0, 16'h0);
    wf(11'h705, 4'h1, 64'h04, 64'hff);
    nmt(8'h80, 8'h05);
    chk(node_state_o, 7'h7f);
    // Speed at the limit is no warning, one above is
    speed_rpm_i = 16'h2710;
    rd(16'h6505, 32'h0, 1'b0);
    speed_rpm_i = 16'h2711;
    wf(11'h085, 4'h8, 64'h0001ff00, '1);
    rd(16'h6505, 32'h1, 1'b0);
    speed_rpm_i = 16'h0;
    wdt_reset_i = 1'b1;
    wf(11'h085, 4'h8, 64'h00015000, '1);
    rd(16'h6505, 32'h4, 1'b0);
    wdt_reset_i = 1'b0;
    // Preset folds into an offset added to the raw position
    raw_pos_i = 32'h100;
    preset_i = 32'h300;
    preset_wr_i = 1'b1;
    @(posedge clk_i);
    #1;
    preset_wr_i = 1'b0;
    rd(16'h6509, 32'h200, 1'b0);
    raw_pos_i = 32'h150;
    repeat (2) @(posedge clk_i);
    #1;
    chk(pos_o, 32'h350);
    // Count keeps running from reset, so capture it; 24 of the next 120 cycles are frozen
    @(posedge clk_i);
    #1;
    od_rd_i = 1'b1;
    od_index_i = 16'h6508;
    @(posedge clk_i);
    #1;
    od_rd_i = 1'b0;
    t0 = od_rdata_o;
    chk(od_rvalid_o, 1'b1);
    chk(od_err_o, 1'b0);
    chk(t0 != 32'h0 && t0 < 32'h00000100, 1'b1);
    repeat (40) @(posedge clk_i);
    #1;
    en = 1'b0;
    raw_pos_i = 32'h400;
    repeat (24) @(posedge clk_i);
    #1;
    chk(pos_o, 32'h350);
    en = 1'b1;
    repeat (54) @(posedge clk_i);
    rd(16'h6508, t0 + 32'd8, 1'b0);
    nmt(8'h81, 8'h05);
    chk(node_state_o, 7'h7f);
    rd(16'h6509, 32'h0, 1'b0);
    u_m.forget();
    u_m.send(11'h705, 1'b1, 4'h0, 16'h0);
    wf(11'h705, 4'h1, 64'h7f, 64'hff);
    // Moved guard identifier and a life time of 2 ms times 3
    cfg(2'h0, 16'h0123);
    cfg(2'h1, 16'h0002);
    cfg(2'h2, 16'h0003);
    u_m.send(11'h123, 1'b1, 4'h0, 16'h0);
    wf(11'h123, 4'h1, 64'hff, 64'hff);
    chk(life_lost_o, 1'b0);
    k = 0;
    while (life_lost_o !== 1'b1 && k < 40) begin
      @(posedge clk_i);
      #1;
      k++;
    end
    chk(life_lost_o, 1'b1);
    nmt(8'h82, 8'h05);
    u_m.forget();
    u_m.send(11'h705, 1'b1, 4'h0, 16'h0);
    wf(11'h705, 4'h1, 64'h7f, 64'hff);
    chk(u_m.tgl_bad, 0);
    give_verdict();
  end
endmodule
